// ==== rtl/sys_reset_defines.vh ====
/*
  constants for the system reset and clock sequencer: register
  indices, field positions, reset values and timing counts.
  assumes byte address = register index times four on apb.
*/
`ifndef SYS_RESET_DEFINES_VH
`define SYS_RESET_DEFINES_VH

// register indices (byte address is index * 4)
`define IDX_OPTIONS          16'hfe00
`define IDX_RESET_CAUSE      16'hfe01
`define IDX_BREAK_FLAG_CTRL  16'hfe03
`define IDX_IRQ_STATUS_ONE   16'hfe04
`define IDX_IRQ_STATUS_TWO   16'hfe05
`define IDX_IRQ_STATUS_THREE 16'hfe06
`define IDX_WDOG_SERVICE     16'hffff

// option register fields
`define OPT_SHORT_STOP_BIT   0
`define OPT_STOP_ENABLE_BIT  1
`define OPT_RESET            8'h00

// break flag control field and reset
`define BFC_CLEAR_ENABLE_BIT 7
`define BFC_RESET            8'h00

// reset cause bit positions
`define CAUSE_POR_BIT        7
`define CAUSE_PIN_BIT        6
`define CAUSE_WDOG_BIT       5
`define CAUSE_OPCODE_BIT     4
`define CAUSE_ADDR_BIT       3
`define CAUSE_MONITOR_BIT    2
`define CAUSE_SUPPLY_BIT     1
`define CAUSE_RESET          8'h80

// reset vectors
`define VECTOR_USER          16'hfffe
`define VECTOR_MONITOR       16'hfefe

// timing counts in reference clock cycles
`define POR_TIMEOUT_CYCLES   13'd4096
`define STOP_LONG_CYCLES     13'd4096
`define STOP_SHORT_CYCLES    13'd32
`define PIN_DRIVE_CYCLES     13'd32
`define RST_HOLD_CYCLES      13'd32
`define PIN_QUAL_CYCLES      13'd67
`define PIN_QUAL_LONG_CYCLES 13'd4163
`define BUS_DIVIDE_LAST      2'd3

`endif

// ==== rtl/sys_counter.v ====
/*
  13-bit free running system counter used as watchdog prescaler.
  assumes one clock (the reference clock) and an active low
  asynchronous reset.
*/
module sys_counter
#(
  parameter WIDTH = 13
)
(
  input  wire             pclk,
  input  wire             presetn,
  input  wire             clear_all,
  input  wire             clear_mid,
  output reg  [WIDTH-1:0] value,
  output reg              tick
);

  // all-ones marks the wrap that feeds the watchdog
  wire wrap;
  assign wrap = &value;

  // count, full clear, or clear of the upper bits on service
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      value <= {WIDTH{1'b0}};
      tick  <= 1'b0;
    end
    else if (clear_all)
    begin
      value <= {WIDTH{1'b0}};
      tick  <= 1'b0;
    end
    else if (clear_mid)
    begin
      // low four bits keep counting, clear the rest
      value <= {{(WIDTH-4){1'b0}}, value[3:0] + 4'h1};
      tick  <= 1'b0;
    end
    else
    begin
      value <= value + {{(WIDTH-1){1'b0}}, 1'b1};
      tick  <= wrap;
    end
  end

endmodule

// ==== rtl/sys_reset_seq.v ====
/*
  system reset and clock sequencer: bus clock enables, reset
  sequencing, reset pin drive, reset cause, watchdog, apb slave.
  assumes pclk is the oscillator reference clock and all inputs
  other than the reset pin are synchronous to it.
*/
`include "sys_reset_defines.vh"
module sys_reset_seq
#(
  parameter ADDR_W = 18,
  parameter WDOG_W = 3
)
(
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  input  wire              pll_select,
  input  wire              pll_output_tick,
  input  wire              power_on_pulse,
  input  wire              low_supply_inhibit,
  input  wire              bad_opcode_decode,
  input  wire              unmapped_access,
  input  wire              opcode_fetch,
  input  wire              monitor_entry_reset,
  input  wire              monitor_mode,
  input  wire              break_state,
  input  wire              rst_test_high_voltage,
  input  wire              irq_test_high_voltage,
  input  wire              stop_request,
  input  wire              wait_request,
  input  wire              wake_event,
  input  wire [15:0]       irq_pending_flag,
  input  wire              reset_pin_in,
  output wire              reset_pin_out,
  output wire              reset_pin_oe,
  output wire              internal_reset,
  output reg  [15:0]       reset_vector,
  output wire              clock_generator_output_en,
  output wire              bus_clk_en,
  output wire              cpu_clk_en,
  output wire              periph_clk_en
);

  // sequencer states
  localparam S_RUN   = 3'd0;
  localparam S_STAB  = 3'd1;
  localparam S_PIN   = 3'd2;
  localparam S_HOLD  = 3'd3;
  localparam S_STOP  = 3'd4;
  localparam S_RECOV = 3'd5;
  localparam S_WAIT  = 3'd6;
  localparam S_EXT   = 3'd7;

  reg  [2:0]  state;          // sequencer state
  reg  [2:0]  next_state;     // next sequencer state
  reg  [12:0] seq_cnt;        // sequence cycle counter
  reg  [12:0] next_seq_cnt;   // next sequence count
  reg         long_type;      // current reset came from por/low supply
  reg  [12:0] pin_low_cnt;    // reset pin low time
  reg         pin_meta;       // synchroniser first stage
  reg         pin_sync;       // synchronised reset pin
  reg  [1:0]  bus_div;        // bus clock divider
  reg  [7:0]  options;        // recovery and stop options
  reg  [7:0]  break_flag_control;
  reg  [7:0]  reset_cause_register;
  reg  [WDOG_W-1:0] wdog_cnt; // watchdog counter

  wire [12:0] sys_value;      // system counter value
  wire        sys_tick;       // system counter wrap
  wire        src_tick;       // clock generator source step
  wire        bus_tick;       // one bus cycle
  wire        long_evt;       // por or low supply event
  wire        short_evt;      // other internal event
  wire        wdog_evt;       // watchdog overflow
  wire        bad_op_evt;     // bad opcode event
  wire        bad_adr_evt;    // bad fetch address event
  wire        wdog_off;       // watchdog disabled
  wire        in_seq;         // internal sequence running
  wire        stop_ok;        // stop is a legal instruction
  wire        wr_en;          // apb write strobe
  wire        setup;          // apb setup phase
  wire        service;        // watchdog service write
  wire        mapped;         // address hits a register
  wire [12:0] stop_delay;     // selected recovery length
  wire [12:0] pin_thresh;     // pin qualification length
  wire [15:0] idx;            // register index from address

  // terminal test for the sequence counter
  function last_count;
    input [12:0] cnt;
    input [12:0] len;
    begin
      last_count = (cnt == len - 13'd1);
    end
  endfunction

  // source step: reference each cycle, pll when selected
  assign src_tick = pll_select ? pll_output_tick : 1'b1;
  assign bus_tick = src_tick & (bus_div == `BUS_DIVIDE_LAST);

  // bus clock divider, free across resets
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bus_div <= 2'd0;
    else if (src_tick)
      bus_div <= bus_div + 2'd1;
  end

  // reset pin synchroniser
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end
    else
    begin
      pin_meta <= reset_pin_in;
      pin_sync <= pin_meta;
    end
  end

  // events
  assign stop_ok   = options[`OPT_STOP_ENABLE_BIT];
  assign bad_op_evt  = bad_opcode_decode | (stop_request & ~stop_ok);
  assign bad_adr_evt = unmapped_access & opcode_fetch;
  assign wdog_off  = (monitor_mode &
                      (rst_test_high_voltage | irq_test_high_voltage))
                   | (break_state & rst_test_high_voltage);
  assign wdog_evt  = sys_tick & (&wdog_cnt) & ~wdog_off;
  assign long_evt  = power_on_pulse | low_supply_inhibit;
  assign short_evt = wdog_evt | bad_op_evt | bad_adr_evt |
                     monitor_entry_reset;
  assign in_seq    = (state == S_STAB) | (state == S_PIN) |
                     (state == S_HOLD);
  assign stop_delay = options[`OPT_SHORT_STOP_BIT] ?
                      `STOP_SHORT_CYCLES : `STOP_LONG_CYCLES;

  // sequencer next state
  always @*
  begin
    next_state   = state;
    next_seq_cnt = seq_cnt + 13'd1;
    if (long_evt)
    begin
      next_state   = S_STAB;
      next_seq_cnt = 13'd0;
    end
    else if (short_evt & ~in_seq)
    begin
      next_state   = S_PIN;
      next_seq_cnt = 13'd0;
    end
    else
    begin
      case (state)
        S_RUN:
        begin
          next_seq_cnt = 13'd0;
          if (~pin_sync)
            next_state = S_EXT;
          else if (stop_request)
            next_state = S_STOP;
          else if (wait_request)
            next_state = S_WAIT;
        end
        S_STAB:
          // oscillator settling, pin held low
          if (last_count(seq_cnt, `POR_TIMEOUT_CYCLES))
          begin
            next_state   = S_PIN;
            next_seq_cnt = 13'd0;
          end
        S_PIN:
          if (last_count(seq_cnt, `PIN_DRIVE_CYCLES))
          begin
            next_state   = S_HOLD;
            next_seq_cnt = 13'd0;
          end
        S_HOLD:
          if (last_count(seq_cnt, `RST_HOLD_CYCLES))
            next_state = S_RUN;
        S_STOP:
        begin
          next_seq_cnt = 13'd0;
          if (~pin_sync | wake_event)
            next_state = S_RECOV;
        end
        S_RECOV:
          if (last_count(seq_cnt, stop_delay))
            next_state = pin_sync ? S_RUN : S_EXT;
        S_WAIT:
        begin
          next_seq_cnt = 13'd0;
          if (~pin_sync)
            next_state = S_EXT;
          else if (wake_event)
            next_state = S_RUN;
        end
        S_EXT:
        begin
          // external pin reset: hold until the pin rises
          next_seq_cnt = 13'd0;
          if (pin_sync)
            next_state = S_RUN;
        end
        default:
        begin
          next_state   = S_RUN;
          next_seq_cnt = 13'd0;
        end
      endcase
    end
  end

  // sequencer registers; reset enters the power-on sequence
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state     <= S_STAB;
      seq_cnt   <= 13'd0;
      long_type <= 1'b1;
    end
    else
    begin
      state   <= next_state;
      seq_cnt <= next_seq_cnt;
      if (long_evt)
        long_type <= 1'b1;
      else if (state == S_RUN)
        long_type <= 1'b0;
    end
  end

  // pin and clock outputs
  assign internal_reset = in_seq | (state == S_EXT);
  assign reset_pin_oe   = (state == S_STAB) | (state == S_PIN);
  assign reset_pin_out  = 1'b0;
  assign clock_generator_output_en = (state != S_STOP);
  assign bus_clk_en     = bus_tick & (state == S_RUN);
  assign cpu_clk_en     = bus_tick & (state == S_RUN);
  assign periph_clk_en  = bus_tick &
                          ((state == S_RUN) | (state == S_WAIT));

  // reset vector select
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reset_vector <= `VECTOR_USER;
    else
      reset_vector <= monitor_mode ? `VECTOR_MONITOR
                                   : `VECTOR_USER;
  end

  // pin low time measurement
  assign pin_thresh = long_type ? `PIN_QUAL_LONG_CYCLES
                                : `PIN_QUAL_CYCLES;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_low_cnt <= 13'd0;
    else if (pin_sync)
      pin_low_cnt <= 13'd0;
    else if (pin_low_cnt != pin_thresh)
      pin_low_cnt <= pin_low_cnt + 13'd1;
  end

  // reset cause register; hardware sets only
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reset_cause_register <= `CAUSE_RESET;
    else if (power_on_pulse)
      reset_cause_register <= `CAUSE_RESET;
    else
    begin
      if (low_supply_inhibit)
        reset_cause_register[`CAUSE_SUPPLY_BIT] <= 1'b1;
      if (wdog_evt)
        reset_cause_register[`CAUSE_WDOG_BIT] <= 1'b1;
      if (bad_op_evt & ~in_seq)
        reset_cause_register[`CAUSE_OPCODE_BIT] <= 1'b1;
      if (bad_adr_evt & ~in_seq)
        reset_cause_register[`CAUSE_ADDR_BIT] <= 1'b1;
      if (monitor_entry_reset)
        reset_cause_register[`CAUSE_MONITOR_BIT] <= 1'b1;
      if (~pin_sync & (pin_low_cnt == pin_thresh - 13'd1))
        reset_cause_register[`CAUSE_PIN_BIT] <= 1'b1;
    end
  end

  // system counter, cleared by internal resets and stop
  sys_counter
  #(
    .WIDTH (13)
  )
  u_sys_counter
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear_all (long_evt | (short_evt & ~in_seq) |
                (state == S_RUN & stop_request & stop_ok)),
    .clear_mid (service),
    .value     (sys_value),
    .tick      (sys_tick)
  );

  // watchdog counter stepped by the system counter wrap
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wdog_cnt <= {WDOG_W{1'b0}};
    else if (internal_reset | service | wdog_off)
      wdog_cnt <= {WDOG_W{1'b0}};
    else if (sys_tick)
      wdog_cnt <= wdog_cnt + {{(WDOG_W-1){1'b0}}, 1'b1};
  end

  // apb decode, zero wait states
  assign idx     = paddr[17:2];
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite;
  assign service = wr_en & (idx == `IDX_WDOG_SERVICE);
  assign mapped  = (idx == `IDX_OPTIONS) | (idx == `IDX_RESET_CAUSE) |
                   (idx == `IDX_BREAK_FLAG_CTRL) |
                   (idx == `IDX_IRQ_STATUS_ONE) |
                   (idx == `IDX_IRQ_STATUS_TWO) |
                   (idx == `IDX_IRQ_STATUS_THREE) |
                   (idx == `IDX_WDOG_SERVICE);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // writable registers, returned to defaults by internal reset
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      options            <= `OPT_RESET;
      break_flag_control <= `BFC_RESET;
    end
    else if (internal_reset)
    begin
      options            <= `OPT_RESET;
      break_flag_control <= `BFC_RESET;
    end
    else if (wr_en)
    begin
      if (idx == `IDX_OPTIONS)
        options <= {6'h00, pwdata[1:0]};
      if (idx == `IDX_BREAK_FLAG_CTRL)
        break_flag_control <= {pwdata[`BFC_CLEAR_ENABLE_BIT], 7'h00};
    end
  end

  // read data captured in the setup phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup)
    begin
      case (idx)
        `IDX_OPTIONS:          prdata <= {24'h000000, options};
        `IDX_RESET_CAUSE:      prdata <= {24'h000000, reset_cause_register};
        `IDX_BREAK_FLAG_CTRL:  prdata <= {24'h000000, break_flag_control};
        `IDX_IRQ_STATUS_ONE:   prdata <= {24'h000000,
                                          irq_pending_flag[5:0], 2'b00};
        `IDX_IRQ_STATUS_TWO:   prdata <= {24'h000000, irq_pending_flag[13:6]};
        `IDX_IRQ_STATUS_THREE: prdata <= {30'h00000000,
                                          irq_pending_flag[15:14]};
        default:               prdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// ==== tb/sys_reset_checker.sv ====
/*
  port checker for the reset and clock sequencer.
  assumes pclk is the only clock and presetn its reset.
*/
module sys_reset_checker
#(
  parameter ADDR_W = 18
)
(
  input logic              pclk,
  input logic              presetn,
  input logic              psel,
  input logic              penable,
  input logic [ADDR_W-1:0] paddr,
  input logic              pslverr,
  input logic              power_on_pulse,
  input logic              low_supply_inhibit,
  input logic              bad_opcode_decode,
  input logic              unmapped_access,
  input logic              opcode_fetch,
  input logic              monitor_entry_reset,
  input logic              monitor_mode,
  input logic              reset_pin_in,
  input logic              reset_pin_oe,
  input logic              internal_reset,
  input logic [15:0]       reset_vector,
  input logic              clock_generator_output_en,
  input logic              bus_clk_en,
  input logic              cpu_clk_en,
  input logic              periph_clk_en
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [12:0] oe_len; // cycles the pin has been pulled
  // length of the current pin drive
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      oe_len <= 13'h0000;
    else if (reset_pin_oe)
      oe_len <= oe_len + 13'h0001;
    else
      oe_len <= 13'h0000;
  // internal source seen while running
  sequence short_evt;
    !internal_reset && (bad_opcode_decode || monitor_entry_reset
      || (unmapped_access && opcode_fetch));
  endsequence
  // reset kept after the pin is released
  sequence hold_phase;
    internal_reset throughout (1'b1 ##31 1'b1);
  endsequence
  short_start_a:
  assert property (short_evt |=> reset_pin_oe && internal_reset)
    else $error("internal source did not start a reset");
  hold_len_a:
  assert property ($fell(reset_pin_oe) |-> hold_phase ##1 !internal_reset)
    else $error("reset hold after pin release not 32 cycles");
  pin_len_a:
  assert property ($fell(reset_pin_oe) |-> oe_len == 13'h0020
    || (oe_len >= 13'h101e && oe_len <= 13'h1022))
    else $error("pin drive length wrong");
  clocks_gated_a:
  assert property (internal_reset |-> !cpu_clk_en && !bus_clk_en
    && !periph_clk_en) else $error("clock enable during reset");
  gen_on_a:
  assert property (internal_reset |-> clock_generator_output_en)
    else $error("clock generator off during reset");
  bus_div_a:
  assert property (bus_clk_en |=> !bus_clk_en [*3])
    else $error("bus clock faster than one in four");
  cpu_wait_a:
  assert property (cpu_clk_en |-> periph_clk_en && bus_clk_en)
    else $error("cpu clock without peripheral clock");
  vector_a:
  assert property (reset_vector ==
    ($past(monitor_mode) ? 16'hfefe : 16'hfffe))
    else $error("reset vector wrong");
  pin_halt_a:
  assert property (!reset_pin_in [*4] |=> internal_reset)
    else $error("low pin did not halt processing");
  long_start_a:
  assert property (power_on_pulse || low_supply_inhibit |->
    ##[1:2] reset_pin_oe && internal_reset)
    else $error("long reset did not pull the pin");
  unmapped_err_a:
  assert property (psel && penable && paddr[ADDR_W-1:2] == 16'hfe02
    |-> pslverr) else $error("unmapped access not refused");
endmodule

// ==== tb/reset_pin_partner.sv ====
/*
  far side of the reset pin: pull-up and an outside party that
  holds the pin low for a requested number of cycles.
  assumes pclk as the reference clock.
*/
module reset_pin_partner
(
  input  logic        pclk,
  input  logic        pull_start,
  input  logic [15:0] pull_len,
  input  logic        reset_pin_out,
  input  logic        reset_pin_oe,
  output logic        reset_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] left = 16'h0000; // cycles of outside hold left
  // outside party keeps the pin low for the asked length
  always @(posedge pclk)
    if (pull_start)
      left <= pull_len;
    else if (left != 16'h0000)
      left <= left - 16'h0001;
  // pull-up wins unless somebody drives low
  assign reset_pin_in = reset_pin_oe ? reset_pin_out :
                        (left != 16'h0000) ? 1'b0 : 1'b1;
endmodule

// ==== tb/tb.sv ====
/*
  bench for the reset and clock sequencer: apb, reset sources,
  pin reset, stop, wait and watchdog. assumes the pin partner.
*/
`include "sys_reset_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pll_select, pll_output_tick, power_on_pulse;
  logic        low_supply_inhibit, bad_opcode_decode, unmapped_access;
  logic        opcode_fetch, monitor_entry_reset, monitor_mode;
  logic        break_state, rst_test_high_voltage, irq_test_high_voltage;
  logic        stop_request, wait_request, wake_event, reset_pin_in;
  logic        reset_pin_out, reset_pin_oe, internal_reset, pull_start;
  logic        clock_generator_output_en, bus_clk_en, cpu_clk_en;
  logic        periph_clk_en;
  logic [15:0] irq_pending_flag, reset_vector, pull_len;
  int          n_errors, checks;
  // 20 MHz reference clock
  always #25 pclk = ~pclk;
  // every design port meets the bench signal of the same name
  sys_reset_seq #(.ADDR_W(18), .WDOG_W(1)) sys_reset_seq_i (.*);
  reset_pin_partner reset_pin_partner_i (.pclk(pclk),
    .pull_start(pull_start), .pull_len(pull_len),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .reset_pin_in(reset_pin_in));
  // verdict and end of run
  task automatic wrap_up;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic hang(input string what);
    n_errors++;
    $display("ERROR %s expected done seen timeout", what);
    wrap_up;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_rng(input string what, input int lo, input int hi,
                         input int got);
    checks++;
    if (got < lo || got > hi)
    begin
      n_errors++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50)
      hang("apb answer");
  endtask
  task automatic rd_chk(input string w, input logic [15:0] idx,
                        input logic [31:0] exp, input logic exp_err);
    logic [31:0] d;
    logic e;
    apb(1'b0, idx, 32'h0000_0000, d, e);
    chk(w, exp, d);
    chk("slave error", exp_err, e);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, idx, d, x, e);
  endtask
  task automatic cause(output logic [31:0] d);
    logic e;
    apb(1'b0, `IDX_RESET_CAUSE, 32'h0000_0000, d, e);
  endtask
  // cycles until internal reset falls
  task automatic wait_run(output int n);
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (internal_reset !== 1'b0 && n < 20000);
    if (n >= 20000)
      hang("leave reset");
  endtask
  task automatic regs;
    irq_pending_flag <= 16'hc3a5;
    rd_chk("flags one", `IDX_IRQ_STATUS_ONE, 32'h94, 1'b0);
    wr(`IDX_IRQ_STATUS_ONE, 32'hff);
    rd_chk("flags one kept", `IDX_IRQ_STATUS_ONE, 32'h94, 1'b0);
    rd_chk("flags two", `IDX_IRQ_STATUS_TWO, 32'h0e, 1'b0);
    rd_chk("flags three", `IDX_IRQ_STATUS_THREE, 32'h03, 1'b0);
    rd_chk("break ctrl", `IDX_BREAK_FLAG_CTRL, 32'h00, 1'b0);
    wr(`IDX_BREAK_FLAG_CTRL, 32'hff);
    rd_chk("break ctrl set", `IDX_BREAK_FLAG_CTRL, 32'h80, 1'b0);
    rd_chk("unmapped", 16'hfe02, 32'h00, 1'b1);
  endtask
  task automatic vec_case;
    @(posedge pclk);
    monitor_mode <= 1'b1;
    repeat (3) @(negedge pclk);
    chk("monitor vector", `VECTOR_MONITOR, reset_vector);
    @(posedge pclk);
    monitor_mode <= 1'b0;
    repeat (3) @(negedge pclk);
    chk("user vector", `VECTOR_USER, reset_vector);
  endtask
  task automatic pin_case(input int len, input logic exp);
    int n;
    logic [31:0] d;
    @(posedge pclk);
    pull_len <= len[15:0];
    pull_start <= 1'b1;
    @(posedge pclk);
    pull_start <= 1'b0;
    repeat (6) @(negedge pclk);
    chk("pin halts", 1'b1, internal_reset);
    wait_run(n);
    cause(d);
    chk("pin cause", exp, d[`CAUSE_PIN_BIT]);
  endtask
  // k: 0 opcode, 1 stop not enabled, 2 fetch address, 3 monitor
  task automatic src_reset(input int k);
    int n;
    logic [31:0] d;
    @(posedge pclk);
    bad_opcode_decode <= (k == 0);
    stop_request <= (k == 1);
    unmapped_access <= (k == 2);
    opcode_fetch <= (k == 2);
    monitor_entry_reset <= (k == 3);
    @(posedge pclk);
    {bad_opcode_decode, stop_request, unmapped_access} <= 3'h0;
    {opcode_fetch, monitor_entry_reset} <= 2'h0;
    wait_run(n);
    chk_rng("internal reset length", 62, 65, n);
    cause(d);
    chk("cause bit", 1'b1, d[k < 2 ? 4 : 5 - k]);
  endtask
  task automatic data_fetch;
    @(posedge pclk);
    unmapped_access <= 1'b1;
    @(posedge pclk);
    unmapped_access <= 1'b0;
    repeat (4) @(negedge pclk);
    chk("data fetch reset", 1'b0, internal_reset);
  endtask
  task automatic stop_case(input logic [31:0] opt, input int lo);
    int n;
    wr(`IDX_OPTIONS, opt);
    @(posedge pclk);
    stop_request <= 1'b1;
    @(posedge pclk);
    stop_request <= 1'b0;
    repeat (8) @(negedge pclk);
    chk("generator in stop", 1'b0, clock_generator_output_en);
    @(posedge pclk);
    wake_event <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (cpu_clk_en !== 1'b1 && n < 5000);
    chk_rng("stop exit", lo, lo + 8, n);
  endtask
  task automatic wait_case;
    int c;
    int p;
    @(posedge pclk);
    wait_request <= 1'b1;
    @(posedge pclk);
    wait_request <= 1'b0;
    c = 0;
    p = 0;
    repeat (16)
    begin
      @(negedge pclk);
      if (cpu_clk_en !== 1'b0)
        c++;
      if (periph_clk_en === 1'b1)
        p++;
    end
    chk_rng("cpu pulses in wait", 0, 0, c);
    chk_rng("peripheral pulses", 4, 4, p);
    @(posedge pclk);
    wake_event <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
  endtask
  // k: 0 low supply, 1 power-on
  task automatic long_case(input int k);
    int n;
    logic [31:0] d;
    @(posedge pclk);
    low_supply_inhibit <= (k == 0);
    power_on_pulse <= (k == 1);
    @(posedge pclk);
    {low_supply_inhibit, power_on_pulse} <= 2'h0;
    wait_run(n);
    chk_rng("long reset length", 4157, 4163, n);
    cause(d);
    if (k == 0)
      chk("supply cause", 1'b1, d[`CAUSE_SUPPLY_BIT]);
    else
      chk("power-on cause", `CAUSE_RESET, d);
  endtask
  task automatic wdog_case;
    int n;
    logic [31:0] d;
    break_state <= 1'b0;
    rst_test_high_voltage <= 1'b0;
    wr(`IDX_WDOG_SERVICE, 32'h0000_0000);
    repeat (5)
    begin
      repeat (4000) @(posedge pclk);
      wr(`IDX_WDOG_SERVICE, 32'h0000_005a);
    end
    @(negedge pclk);
    chk("serviced watchdog", 1'b0, internal_reset);
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (internal_reset !== 1'b1 && n < 17000);
    if (n >= 17000)
      hang("watchdog expiry");
    chk("watchdog pulls pin", 1'b1, reset_pin_oe);
    wait_run(n);
    cause(d);
    chk("watchdog cause", 1'b1, d[`CAUSE_WDOG_BIT]);
  endtask
  // main sequence
  initial
  begin
    int n;
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, pll_select, pll_output_tick} = 5'h00;
    {power_on_pulse, low_supply_inhibit, bad_opcode_decode} = 3'h0;
    {unmapped_access, opcode_fetch, monitor_entry_reset} = 3'h0;
    {monitor_mode, irq_test_high_voltage, stop_request} = 3'h0;
    {wait_request, wake_event, pull_start} = 3'h0;
    break_state = 1'b1;
    rst_test_high_voltage = 1'b1;
    {paddr, pwdata, irq_pending_flag, pull_len} = 82'h0;
    n_errors = 0;
    checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wait_run(n);
    chk_rng("power-up length", 4157, 4163, n);
    rd_chk("cause after power-up", `IDX_RESET_CAUSE, 32'h80, 1'b0);
    regs;
    vec_case;
    pin_case(20, 1'b0);
    pin_case(80, 1'b1);
    for (int k = 0; k < 4; k++)
      src_reset(k);
    data_fetch;
    stop_case(32'h03, 32);
    stop_case(32'h02, 4096);
    wait_case;
    long_case(0);
    long_case(1);
    wdog_case;
    wrap_up;
  end
endmodule
bind sys_reset_seq sys_reset_checker #(.ADDR_W(ADDR_W))
  sys_reset_checker_i (.*);
